// File: include/frame_layout_pkg.sv
package frame_layout_pkg;
   // frame geometry
   localparam int DATA_ROWS = 190;
   localparam int PARITY_ROWS = 82;
   localparam logic [8:0] LAST_DATA_ROW = 9'h0BD;
   localparam logic [8:0] FIRST_PARITY_ROW = 9'h0BE;
   localparam logic [8:0] LAST_PARITY_ROW = 9'h10F;
   localparam logic [8:0] VRES_ROW = 9'h110;
   localparam int ROWS = DATA_ROWS + PARITY_ROWS + 1;
   localparam logic [5:0] FIRST_BODY = 6'h02;
   localparam logic [5:0] LAST_PAYLOAD = 6'h17;
   localparam logic [5:0] FIRST_CHECK = 6'h18;
   localparam logic [5:0] LAST_COL = 6'h23;
   localparam logic [13:0] BODY_BYTES = 14'h0022;
   localparam logic [5:0] VRES_LAST = 6'h21;
   // status byte 0 fields
   localparam int S0_CHECK1 = 7;
   localparam int S0_CORR1 = 6;
   localparam int S0_RAW = 5;
   localparam int S0_FRAME = 4;
   localparam int S0_BLOCK = 3;
   localparam int S0_CODE = 2;
   // status byte 1 fields
   localparam int S1_TRAFFIC = 7;
   localparam int S1_PARITY = 6;
   localparam int S1_IRQ1 = 5;
   localparam int S1_CHECK2 = 4;
   localparam int S1_CORR2 = 3;
   localparam int S1_MARKER = 2;
   // block-number markers and group bounds
   localparam logic [8:0] MARK_B [4] = '{9'h001, 9'h00E, 9'h089, 9'h096};
   localparam logic [8:0] MARK_A [4] = '{9'h001, 9'h03D, 9'h083, 9'h0BF};
   localparam logic [8:0] GRP_B [3] = '{9'h00D, 9'h088, 9'h095};
   localparam logic [8:0] GRP_A [3] = '{9'h03C, 9'h082, 9'h0BE};
   // second-pass interrupt lands on the 13th packet (block 12)
   localparam logic [8:0] IRQ_BLOCK = 9'h00C;
   // register offsets
   localparam logic [7:0] REG_DATA = 8'h38;
   localparam logic [7:0] REG_BYTE_PTR = 8'h3B;
   localparam logic [7:0] REG_PKT_LO = 8'h3C;
   localparam logic [7:0] REG_PKT_HI = 8'h3D;
   localparam logic [7:0] REG_CTRL = 8'h3E;
   localparam logic [7:0] REG_STAT = 8'h3F;
   localparam int CTRL_FORMAT_B = 0;
   localparam int CTRL_TEST_PARITY = 1;
   localparam int CTRL_TEST_START = 2;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef struct packed {
      logic [7:0] header;
      logic [8:0] block;
      logic first_pass_irq_source;
   } pkt_info_t;

   typedef struct packed {
      logic check_fail_pass_two;
      logic correction_fail_pass_two;
      logic traffic_service_packet;
   } fix_result_t;

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT, S_WRITE} seq_state_t;
endpackage

// File: rtl/block_group_class.sv
// classifies a block number into group code and group start marker
module block_group_class
   import frame_layout_pkg::*;
(
   // block under test
   input wire logic [8:0] i_block,
   input wire logic i_format_b,
   // classification
   output logic o_marker,
   output logic [1:0] o_group
);
   // marker compares against the four group starts of the chosen format
   always_comb
   begin
      o_marker = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         if (i_block == (i_format_b ? MARK_B[k] : MARK_A[k]))
         begin
            o_marker = 1'b1;
         end
      end
   end

   // group code counts how many bounds the block has reached
   always_comb
   begin
      o_group = 2'h0;
      for (int k = 0; k < 3; k++)
      begin
         if (i_block >= (i_format_b ? GRP_B[k] : GRP_A[k]))
         begin
            o_group = 2'(k + 1);
         end
      end
   end
endmodule

// File: rtl/frame_memory_layout.sv
// Contract
// - frame: 190 data, 82 parity, 1 result
// - bytes 0-1 status, 2-23 payload, 24-35 check
// - parity rows skip second pass by default
// - status byte 0 is first-pass header
// - first_pass_header bit7: first-pass check failed
// - first_pass_header bit6: first-pass correction failed
// - first_pass_header bit5: raw packet check failed
// - first_pass_header bit4: frame lock held
// - first_pass_header bit3: block lock held
// - first_pass_header bits2-0: block code detection
// - byte1 bit7: traffic service packet
// - byte1 bit6: parity packet under frame lock
// - byte1 bit5: packet raised first-pass interrupt
// - byte1 bits4,3: second-pass errors, good if 0
// - byte1 bit2: group start block marker
// - byte1 bits1-0: block number group code
// - data port read advances memory address
// - after frame, correct, interrupt at 13th packet
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module frame_memory_layout
   import frame_layout_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   // first-pass packet stream
   input wire logic i_pkt_start,
   input wire pkt_info_t i_pkt,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   // vertical correction results
   input wire logic i_vres_valid,
   input wire logic [5:0] i_vres_index,
   input wire logic [7:0] i_vres_byte,
   // second-pass corrector handshake
   output logic o_fix_req,
   output logic [8:0] o_fix_row,
   input wire logic i_fix_done,
   input wire fix_result_t i_fix,
   // second-pass receive event
   output logic o_pass_two_irq
);
   logic [7:0] stat0_mem [LAST_PARITY_ROW + 1];
   logic [7:0] stat1_mem [LAST_PARITY_ROW + 1];
   logic [7:0] data_mem [ROWS * 34];
   logic [LAST_PARITY_ROW:0] irq_seen_q;
   logic [8:0] rx_row_q;
   logic [5:0] rx_col_q;
   logic rx_on_q;
   logic full_frame_q;
   logic rx_start;
   logic rx_wr;
   logic frame_end;
   logic [13:0] rx_idx;
   logic rx_marker;
   logic [1:0] rx_group;
   logic [7:0] rx_stat1;
   logic vres_pend_q;
   logic [5:0] vres_idx_q;
   logic [7:0] vres_byte_q;
   logic vres_wr;
   logic [5:0] vres_idx;
   logic [7:0] vres_byte;
   seq_state_t seq_q;
   logic [8:0] seq_row_q;
   logic [8:0] seq_last_q;
   fix_result_t fix_q;
   logic seq_marker;
   logic [1:0] seq_group;
   logic seq_wr;
   logic p2_ready_q;
   logic seq_finish;
   logic [5:0] byte_ptr_q;
   logic [8:0] pkt_ptr_q;
   logic [1:0] ctrl_q;
   logic test_start;
   logic data_rd;
   logic [13:0] host_idx;

   // only packets under frame lock are accumulated
   assign rx_start = i_pkt_start & i_pkt.header[S0_FRAME];
   assign rx_wr = i_byte_valid & rx_on_q;
   assign frame_end = rx_wr & (rx_col_q == LAST_COL) & (rx_row_q == LAST_PARITY_ROW);
   assign rx_idx = 14'(rx_row_q) * BODY_BYTES + 14'(rx_col_q) - 14'(FIRST_BODY);
   assign test_start = i_wr & (i_addr == REG_CTRL) & i_wdata[CTRL_TEST_START];
   assign data_rd = i_rd & (i_addr == REG_DATA);
   assign host_idx = 14'(pkt_ptr_q) * BODY_BYTES + 14'(byte_ptr_q) - 14'(FIRST_BODY);

   block_group_class rx_class (
      .i_block(i_pkt.block),
      .i_format_b(ctrl_q[CTRL_FORMAT_B]),
      .o_marker(rx_marker),
      .o_group(rx_group)
   );

   block_group_class seq_class (
      .i_block(seq_row_q),
      .i_format_b(ctrl_q[CTRL_FORMAT_B]),
      .o_marker(seq_marker),
      .o_group(seq_group)
   );

   // second-pass bits start as first-pass copies; untouched rows keep them
   always_comb
   begin
      rx_stat1 = 8'h00;
      rx_stat1[S1_PARITY] = i_pkt.block >= FIRST_PARITY_ROW;
      rx_stat1[S1_IRQ1] = i_pkt.first_pass_irq_source;
      rx_stat1[S1_CHECK2] = i_pkt.header[S0_CHECK1];
      rx_stat1[S1_CORR2] = i_pkt.header[S0_CORR1];
      rx_stat1[S1_MARKER] = rx_marker;
      rx_stat1[1:0] = rx_group;
   end

   // receive row and column tracking
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_row_q <= 9'h000;
         rx_col_q <= 6'h00;
         rx_on_q <= 1'b0;
      end
      else if (rx_start && i_pkt.block <= LAST_PARITY_ROW)
      begin
         rx_row_q <= i_pkt.block;
         rx_col_q <= FIRST_BODY;
         rx_on_q <= 1'b1;
      end
      else if (rx_wr)
      begin
         rx_col_q <= rx_col_q + 6'h01;
         rx_on_q <= rx_col_q != LAST_COL;
      end
   end

   // the second pass needs a frame caught from its first row
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         full_frame_q <= 1'b0;
      end
      else if (i_pkt_start)
      begin
         full_frame_q <= rx_start & (full_frame_q | (i_pkt.block == 9'h000));
      end
   end

   // per-row first-pass interrupt record
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_seen_q <= '0;
      end
      else if (rx_start && i_pkt.block <= LAST_PARITY_ROW)
      begin
         irq_seen_q[i_pkt.block] <= i_pkt.first_pass_irq_source;
      end
   end

   // status bytes: header copied verbatim, byte1 rewritten after pass two
   always_ff @(posedge i_clock)
   begin
      if (rx_start && i_pkt.block <= LAST_PARITY_ROW)
      begin
         stat0_mem[i_pkt.block] <= i_pkt.header;
         stat1_mem[i_pkt.block] <= rx_stat1;
      end
      else if (seq_wr)
      begin
         stat1_mem[seq_row_q] <= {fix_q.traffic_service_packet,
            seq_row_q >= FIRST_PARITY_ROW, irq_seen_q[seq_row_q],
            fix_q.check_fail_pass_two, fix_q.correction_fail_pass_two,
            seq_marker, seq_group};
      end
   end

   // vertical results wait, one deep, until packet bytes free the port
   assign vres_idx = vres_pend_q ? vres_idx_q : i_vres_index;
   assign vres_byte = vres_pend_q ? vres_byte_q : i_vres_byte;
   assign vres_wr = ~rx_wr & (vres_pend_q | i_vres_valid) & (vres_idx <= VRES_LAST);

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         vres_pend_q <= 1'b0;
         vres_idx_q <= 6'h00;
         vres_byte_q <= 8'h00;
      end
      else if (rx_wr)
      begin
         vres_pend_q <= vres_pend_q | i_vres_valid;
         if (!vres_pend_q)
         begin
            vres_idx_q <= i_vres_index;
            vres_byte_q <= i_vres_byte;
         end
      end
      else
      begin
         // a second result arriving during a pending write is queued behind it
         vres_pend_q <= vres_pend_q & i_vres_valid;
         vres_idx_q <= i_vres_index;
         vres_byte_q <= i_vres_byte;
      end
   end

   // body bytes of rows 0..271 and the result row share one write port
   always_ff @(posedge i_clock)
   begin
      if (rx_wr)
      begin
         data_mem[rx_idx] <= i_byte;
      end
      else if (vres_wr)
      begin
         data_mem[14'(VRES_ROW) * BODY_BYTES + 14'(vres_idx)] <= vres_byte;
      end
   end

   // second-pass sequencer; rx status writes win, so the sequencer waits
   assign seq_wr = (seq_q == S_WRITE) & ~(rx_start & (i_pkt.block <= LAST_PARITY_ROW));
   assign seq_finish = seq_wr & (seq_row_q == seq_last_q);

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         seq_q <= S_IDLE;
         seq_row_q <= 9'h000;
         seq_last_q <= LAST_DATA_ROW;
         fix_q <= '0;
      end
      else
      begin
         case (seq_q)
            S_IDLE:
            begin
               if ((frame_end && full_frame_q) || test_start)
               begin
                  seq_row_q <= 9'h000;
                  // parity rows only on the explicit test pass
                  // the opt-in bit rides in the same write as the start bit
                  seq_last_q <= (test_start && i_wdata[CTRL_TEST_PARITY]) ?
                     LAST_PARITY_ROW : LAST_DATA_ROW;
                  seq_q <= S_REQ;
               end
            end
            S_REQ:
            begin
               seq_q <= S_WAIT;
            end
            S_WAIT:
            begin
               if (i_fix_done)
               begin
                  fix_q <= i_fix;
                  seq_q <= S_WRITE;
               end
            end
            S_WRITE:
            begin
               if (seq_finish)
               begin
                  seq_q <= S_IDLE;
               end
               else if (seq_wr)
               begin
                  seq_row_q <= seq_row_q + 9'h001;
                  seq_q <= S_REQ;
               end
            end
            default:
            begin
               seq_q <= S_IDLE;
            end
         endcase
      end
   end

   // one-cycle request to the corrector per row
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_fix_req <= 1'b0;
         o_fix_row <= 9'h000;
      end
      else
      begin
         o_fix_req <= seq_q == S_REQ;
         if (seq_q == S_REQ)
         begin
            o_fix_row <= seq_row_q;
         end
      end
   end

   // event held until the 13th packet of the next frame; a finish wins
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         p2_ready_q <= 1'b0;
         o_pass_two_irq <= 1'b0;
      end
      else
      begin
         o_pass_two_irq <= p2_ready_q & rx_start & (i_pkt.block == IRQ_BLOCK);
         if (seq_finish)
         begin
            p2_ready_q <= 1'b1;
         end
         else if (rx_start && i_pkt.block == IRQ_BLOCK)
         begin
            p2_ready_q <= 1'b0;
         end
      end
   end

   // host pointer: wraps after byte 35 and after row 272
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         byte_ptr_q <= 6'h00;
         pkt_ptr_q <= 9'h000;
      end
      else if (data_rd)
      begin
         byte_ptr_q <= (byte_ptr_q >= LAST_COL) ? 6'h00 : byte_ptr_q + 6'h01;
         if (byte_ptr_q >= LAST_COL)
         begin
            pkt_ptr_q <= (pkt_ptr_q >= VRES_ROW) ? 9'h000 : pkt_ptr_q + 9'h001;
         end
      end
      else if (i_wr)
      begin
         case (i_addr)
            REG_BYTE_PTR: byte_ptr_q <= i_wdata[5:0];
            REG_PKT_LO: pkt_ptr_q <= {pkt_ptr_q[8], i_wdata};
            REG_PKT_HI: pkt_ptr_q <= {i_wdata[0], pkt_ptr_q[7:0]};
            default: pkt_ptr_q <= pkt_ptr_q;
         endcase
      end
   end

   // control: format select and parity test opt-in
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_q <= CTRL_RESET;
      end
      else if (i_wr && i_addr == REG_CTRL)
      begin
         ctrl_q <= i_wdata[1:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rd_data <= 8'h00;
      end
      else if (!i_rd)
      begin
         o_rd_data <= 8'h00;
      end
      else
      begin
         case (i_addr)
            REG_DATA:
            begin
               if (pkt_ptr_q > VRES_ROW || byte_ptr_q > LAST_COL)
               begin
                  o_rd_data <= 8'h00;
               end
               else if (byte_ptr_q >= FIRST_BODY)
               begin
                  o_rd_data <= data_mem[host_idx];
               end
               else if (pkt_ptr_q == VRES_ROW)
               begin
                  o_rd_data <= 8'h00;
               end
               else
               begin
                  o_rd_data <= byte_ptr_q[0] ? stat1_mem[pkt_ptr_q] : stat0_mem[pkt_ptr_q];
               end
            end
            REG_BYTE_PTR: o_rd_data <= {2'h0, byte_ptr_q};
            REG_PKT_LO: o_rd_data <= pkt_ptr_q[7:0];
            REG_PKT_HI: o_rd_data <= {7'h00, pkt_ptr_q[8]};
            REG_CTRL: o_rd_data <= {6'h00, ctrl_q};
            REG_STAT: o_rd_data <= {6'h00, p2_ready_q, seq_q != S_IDLE};
            default: o_rd_data <= 8'h00;
         endcase
      end
   end

   a_default_skip: assert property (@(posedge i_clock) disable iff (i_rst)
      (seq_q == S_IDLE && frame_end && full_frame_q && !test_start)
      |=> seq_last_q == LAST_DATA_ROW)
      else $error("parity rows entered pass two without test request");

   a_row_bound: assert property (@(posedge i_clock) disable iff (i_rst)
      o_fix_req |-> o_fix_row <= LAST_PARITY_ROW)
      else $error("corrector asked for a row beyond the parity rows");

   a_body_column: assert property (@(posedge i_clock) disable iff (i_rst)
      rx_on_q |-> (rx_col_q >= FIRST_BODY && rx_col_q <= LAST_COL))
      else $error("body byte written into a status column");

   a_ptr_advance: assert property (@(posedge i_clock) disable iff (i_rst)
      (data_rd && byte_ptr_q < LAST_COL) |=> byte_ptr_q == $past(byte_ptr_q) + 6'h01)
      else $error("data port read did not advance the byte pointer");

   a_ptr_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
      (data_rd && byte_ptr_q == LAST_COL && pkt_ptr_q < VRES_ROW)
      |=> byte_ptr_q == 6'h00 && pkt_ptr_q == $past(pkt_ptr_q) + 9'h001)
      else $error("row end did not wrap to the next packet");

   a_irq_block: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pass_two_irq |-> $past(i_pkt.block) == IRQ_BLOCK && $past(p2_ready_q))
      else $error("second-pass event off the 13th packet");

   a_irq_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pass_two_irq |=> !o_pass_two_irq)
      else $error("second-pass event longer than one cycle");

   a_vres_row: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_vres_valid && !vres_pend_q && !rx_wr && i_vres_index <= VRES_LAST)
      |=> data_mem[14'(VRES_ROW) * BODY_BYTES + 14'($past(i_vres_index))] == $past(i_vres_byte))
      else $error("vertical result not stored in the result row");

   a_req_order: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_q == S_REQ |=> o_fix_req && seq_q == S_WAIT ##1 !o_fix_req)
      else $error("corrector request not a single pulse");

   a_parity_mark: assert property (@(posedge i_clock) disable iff (i_rst)
      (rx_start && i_pkt.block <= LAST_PARITY_ROW)
      |=> stat1_mem[$past(i_pkt.block)][S1_PARITY] == ($past(i_pkt.block) > LAST_DATA_ROW))
      else $error("parity mark disagrees with block number");
endmodule

// File: test/fix_corrector_model.sv
// stand-in for the second-pass corrector that answers the block's row requests
module fix_corrector_model
   import frame_layout_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // request from the block, answer delay from the test
   input wire logic i_fix_req,
   input wire logic [8:0] i_fix_row,
   input wire logic [3:0] i_delay,
   // answer
   output logic o_fix_done,
   output fix_result_t o_fix
);
   logic busy_q;
   logic [3:0] wait_q;
   logic [8:0] row_q;

   // one answer per request; results depend on the row only, and check and
   // correction are swapped against the header so a stale byte shows up
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         busy_q <= 1'b0;
         wait_q <= 4'h0;
         row_q <= 9'h000;
         o_fix_done <= 1'b0;
         o_fix <= '0;
      end
      else if (i_fix_req)
      begin
         busy_q <= 1'b1;
         wait_q <= i_delay;
         row_q <= i_fix_row;
         o_fix_done <= 1'b0;
         o_fix <= ~o_fix; // result lines carry noise outside the answer
      end
      else if (busy_q && wait_q == 4'h0)
      begin
         busy_q <= 1'b0;
         o_fix_done <= 1'b1;
         o_fix <= '{check_fail_pass_two: row_q[1], correction_fail_pass_two: row_q[0],
                    traffic_service_packet: row_q[2]};
      end
      else
      begin
         wait_q <= wait_q - 4'h1;
         o_fix_done <= 1'b0;
         o_fix <= ~o_fix;
      end
   end
endmodule

// File: test/frame_memory_layout_test.sv
module frame_memory_layout_test
   import frame_layout_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_clock, i_rst, i_wr, i_rd, i_pkt_start, i_byte_valid, i_vres_valid;
   logic o_fix_req, i_fix_done, o_pass_two_irq;
   logic [7:0] i_addr, i_wdata, o_rd_data, i_byte, i_vres_byte, rd_v;
   logic [5:0] i_vres_index;
   logic [8:0] o_fix_row, last_blk, irq_blk;
   logic [3:0] fix_delay;
   pkt_info_t i_pkt;
   fix_result_t i_fix;
   int error_cnt, checks_done, irq_cnt;
   logic [8:0] blks [2][8] = '{'{9'h001, 9'h00E, 9'h089, 9'h096, 9'h00C, 9'h00D, 9'h094, 9'h095},
                               '{9'h001, 9'h03D, 9'h083, 9'h0BF, 9'h03B, 9'h03C, 9'h0BD, 9'h0BE}};

   frame_memory_layout uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_pkt_start(i_pkt_start), .i_pkt(i_pkt), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
      .i_vres_valid(i_vres_valid), .i_vres_index(i_vres_index), .i_vres_byte(i_vres_byte),
      .o_fix_req(o_fix_req), .o_fix_row(o_fix_row), .i_fix_done(i_fix_done), .i_fix(i_fix),
      .o_pass_two_irq(o_pass_two_irq));

   fix_corrector_model corr (.i_clock(i_clock), .i_rst(i_rst), .i_fix_req(o_fix_req),
      .i_fix_row(o_fix_row), .i_delay(fix_delay), .o_fix_done(i_fix_done), .o_fix(i_fix));

   // clock
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   // pulse counter; remembers which packet start preceded each pulse
   always @(posedge i_clock)
   begin
      if (o_pass_two_irq === 1'b1)
      begin
         irq_cnt++;
         irq_blk = last_blk;
      end
   end

   // expected status byte 1, format A when fb is 0
   function automatic logic [7:0] s1(input logic [8:0] b, input logic fb, irq, c2, e2, tr);
      logic mk;
      logic [1:0] g;
      mk = fb ? (b == 9'h001 || b == 9'h00E || b == 9'h089 || b == 9'h096)
              : (b == 9'h001 || b == 9'h03D || b == 9'h083 || b == 9'h0BF);
      if (fb)
         g = (b <= 9'h00C) ? 2'h0 : (b <= 9'h087) ? 2'h1 : (b <= 9'h094) ? 2'h2 : 2'h3;
      else
         g = (b <= 9'h03B) ? 2'h0 : (b <= 9'h081) ? 2'h1 : (b <= 9'h0BD) ? 2'h2 : 2'h3;
      return {tr, b >= 9'h0BE, irq, c2, e2, mk, g};
   endfunction

   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 rd_v = o_rd_data;
   endtask

   task automatic send_pkt(input logic [8:0] b, input logic [7:0] h, input logic irq);
      @(posedge i_clock);
      i_pkt_start <= 1'b1;
      i_pkt <= '{header: h, block: b, first_pass_irq_source: irq};
      last_blk <= b;
      for (int c = 2; c < 36; c++)
      begin
         @(posedge i_clock);
         i_pkt_start <= 1'b0;
         i_byte_valid <= 1'b1;
         i_byte <= b[7:0] ^ c[7:0];
      end
      @(posedge i_clock);
      i_byte_valid <= 1'b0;
   endtask

   // one pointer load, then 36 reads that rely on the auto-advance
   task automatic check_row(input logic [8:0] r, input logic [7:0] b0, input logic [7:0] b1);
      logic [7:0] e;
      wr(8'h3B, 8'h00);
      wr(8'h3C, r[7:0]);
      wr(8'h3D, {7'h00, r[8]});
      for (int c = 0; c < 36; c++)
      begin
         rd(8'h38);
         e = (c == 0) ? b0 : (c == 1) ? b1 : (r == 9'h110) ? 8'hBE + c[7:0] : r[7:0] ^ c[7:0];
         chk($sformatf("row %0d byte %0d", r, c), rd_v, e);
      end
   endtask

   // bounded poll of the pass status
   task automatic wait_pass();
      for (int n = 0; n < 4000; n++)
      begin
         rd(8'h3F);
         if (rd_v === 8'h02)
            break;
      end
      chk("pass status", rd_v, 8'h02);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog well above the expected 16k cycles
   initial
   begin
      repeat (80000) @(posedge i_clock);
      error_cnt++;
      final_report();
   end

   initial
   begin
      logic [7:0] h;
      logic [8:0] b;
      {i_wr, i_rd, i_pkt_start, i_byte_valid, i_vres_valid} = 5'h00;
      {i_addr, i_wdata, i_byte, i_vres_byte} = 32'h0000_0000;
      i_vres_index = 6'h00;
      i_pkt = '0;
      last_blk = 9'h000;
      irq_blk = 9'h000;
      fix_delay = 4'h0;
      error_cnt = 0;
      checks_done = 0;
      irq_cnt = 0;
      i_rst = 1'b1;
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      // unmapped place: write ignored, read gives zero
      wr(8'h10, 8'hFF);
      rd(8'h10);
      chk("unmapped read", rd_v, 8'h00);
      // status fields at group edges, format B then A, every code value
      for (int f = 0; f < 2; f++)
      begin
         wr(8'h3E, {7'h00, f == 0});
         for (int i = 0; i < 8; i++)
         begin
            b = blks[f][i];
            h = {i[2:0], 1'b1, ~i[1], i[2:0]};
            send_pkt(b, h, i[0]);
            check_row(b, h, s1(b, f == 0, i[0], h[7], h[6], 1'b0));
         end
      end
      // a packet without frame lock leaves the stored row alone
      send_pkt(9'h0BE, 8'h08, 1'b0);
      check_row(9'h0BE, 8'hF7, s1(9'h0BE, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
      $display("test status fields done");
      // whole frame from block 0, vertical results after the first packet
      wr(8'h3E, 8'h00);
      for (int k = 0; k < 272; k++)
      begin
         send_pkt(k[8:0], {k[0], k[1], 6'h18}, k[3]);
         for (int v = 0; v < 34 && k == 0; v++)
         begin
            @(posedge i_clock);
            i_vres_valid <= 1'b1;
            i_vres_index <= v[5:0];
            i_vres_byte <= 8'hC0 + v[7:0];
            @(posedge i_clock);
            i_vres_valid <= 1'b0;
         end
      end
      wait_pass();
      chk("early pulse", irq_cnt[8:0], 9'h000);
      check_row(9'h005, 8'h98, s1(9'h005, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
      check_row(9'h0BD, 8'h98, s1(9'h0BD, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
      check_row(9'h0C9, 8'h98, s1(9'h0C9, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
      check_row(9'h110, 8'h00, 8'h00);
      $display("test frame pass done");
      // extra pass over the data and parity rows, slow answers
      fix_delay <= 4'h5;
      wr(8'h3E, 8'h06);
      wait_pass();
      check_row(9'h0C9, 8'h98, s1(9'h0C9, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
      $display("test parity pass done");
      // receive event lands on the 13th packet of the next frame
      for (int k = 0; k < 12; k++)
         send_pkt(k[8:0], 8'h18, 1'b0);
      chk("pulse before 13th", irq_cnt[8:0], 9'h000);
      send_pkt(9'h00C, 8'h18, 1'b0);
      chk("pulse count", irq_cnt[8:0], 9'h001);
      chk("pulse block", irq_blk, 9'h00C);
      $display("test receive event done");
      final_report();
   end
endmodule
